// ### rtl/put_pkg.sv
// What this block does
// - Trigger confirmation output follows the trigger coil, three clock cycles later (two synchroniser stages and an output register).
// - On trigger pickup latch the input value, then hand it to the network.
// - Failed send sets error output until the next trigger pickup.
// - Full signed 32-bit value is carried unchanged into buffer and transmission.
// - Send jobs run only while the station network reports correct operation.
// - Parameter-display flag selects visibility; reset value is displayed.
// - A send job starts only on a rising edge of the trigger coil.
// - Active output is high while the value is buffered and being transferred.
package put_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  STATUS_ADDR    = 4'h4;
  localparam logic [3:0]  IRQ_STAT_ADDR  = 4'h8;
  localparam logic [3:0]  IRQ_MASK_ADDR  = 4'hC;
  localparam int          DISPLAY_BIT    = 0;
  localparam logic        DISPLAY_RESET  = 1'b1;
  localparam int          VALUE_WIDTH    = 32;

  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int          IRQ_SENT_BIT   = 0;
  localparam int          IRQ_ERROR_BIT  = 1;
  localparam int          IRQ_WIDTH      = 2;

  typedef enum logic [1:0] {IDLE, SEND, WAIT_DONE} send_state_type;

endpackage

// ### rtl/put_sender.sv
`timescale 1ns/1ps
module put_sender #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,        // Clock.
  input  wire logic             rst_in,        // Synchronous reset.
  input  wire logic             trigger_in,    // Synchronised trigger coil.
  input  wire logic [WIDTH-1:0] value_in,      // Value to capture.
  input  wire logic             net_ok_in,     // Network running properly.
  input  wire logic             tx_ready_in,   // Network accepts request.
  input  wire logic             tx_done_in,    // Completion strobe.
  input  wire logic             tx_fail_in,    // Completion failed.
  output logic                  tx_valid_out,  // Request valid.
  output logic [WIDTH-1:0]      tx_data_out,   // Buffered value.
  output logic                  active_out,    // Buffering/transfer active.
  output logic                  error_out,     // Transfer error.
  output logic                  sent_ev_out,   // Pulse: sent ok.
  output logic                  err_ev_out     // Pulse: send failed.
);

  put_pkg::send_state_type state;
  put_pkg::send_state_type next_state;
  logic             trig_prev;
  logic [WIDTH-1:0] buffer;
  logic [WIDTH-1:0] next_buffer;
  logic             error;
  logic             next_error;
  logic             sent_ev;
  logic             next_sent_ev;
  logic             err_ev;
  logic             next_err_ev;
  logic             pickup;

  assign pickup = trigger_in & ~trig_prev;

  always_comb
  begin
    next_state   = state;
    next_buffer  = buffer;
    next_error   = error;
    next_sent_ev = 1'b0;
    next_err_ev  = 1'b0;
    if (pickup)
    begin
      next_error = 1'b0;
    end
    unique case (state)
      put_pkg::IDLE:
      begin
        if (pickup && net_ok_in)
        begin
          next_buffer = value_in;
          next_state  = put_pkg::SEND;
        end
        else if (pickup)
        begin
          // No job is started on a dead network; the lost value is a failed send.
          next_error  = 1'b1;
          next_err_ev = 1'b1;
        end
      end
      put_pkg::SEND:
      begin
        // A network fault aborts the job and counts as a failed send.
        if (!net_ok_in)
        begin
          next_state  = put_pkg::IDLE;
          next_error  = 1'b1;
          next_err_ev = 1'b1;
        end
        else if (tx_ready_in)
        begin
          next_state = put_pkg::WAIT_DONE;
        end
      end
      put_pkg::WAIT_DONE:
      begin
        if (tx_done_in)
        begin
          next_state   = put_pkg::IDLE;
          next_error   = tx_fail_in;
          next_err_ev  = tx_fail_in;
          next_sent_ev = ~tx_fail_in;
        end
        else if (!net_ok_in)
        begin
          next_state  = put_pkg::IDLE;
          next_error  = 1'b1;
          next_err_ev = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state     <= put_pkg::IDLE;
      trig_prev <= 1'b0;
      buffer    <= '0;
      error     <= 1'b0;
      sent_ev   <= 1'b0;
      err_ev    <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      trig_prev <= trigger_in;
      buffer    <= next_buffer;
      error     <= next_error;
      sent_ev   <= next_sent_ev;
      err_ev    <= next_err_ev;
    end
  end

  assign tx_valid_out = (state == put_pkg::SEND) && net_ok_in;
  assign tx_data_out  = buffer;
  assign active_out   = (state != put_pkg::IDLE);
  assign error_out    = error;
  assign sent_ev_out  = sent_ev;
  assign err_ev_out   = err_ev;

endmodule

// ### rtl/put_block.sv
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module put_block (
  input  wire logic        CLOCK_IN,        // 40 MHz clock.
  input  wire logic        SYS_RST_IN,      // Synchronous reset, active high.
  input  wire logic        TRIGGER_COIL_IN, // Send trigger coil (asynchronous).
  input  wire logic [31:0] PUT_VALUE_IN,    // Signed value to send.
  input  wire logic        NET_OK_IN,       // Station network running properly.
  input  wire logic        TX_READY_IN,     // Network accepts request.
  input  wire logic        TX_DONE_IN,      // Completion strobe.
  input  wire logic        TX_FAIL_IN,      // Completion failed, with done.
  output logic             TX_VALID_OUT,    // Send request.
  output logic [31:0]      TX_DATA_OUT,     // Value to transmit.
  output logic             CONFIRM_OUT,     // Trigger confirmation contact.
  output logic             ACTIVE_OUT,      // Buffer/transfer active contact.
  output logic             ERROR_OUT,       // Send error contact.
  output logic             IRQ_OUT,         // Level interrupt.
  input  wire logic [31:0] WB_ADR_I,        // Wishbone address.
  input  wire logic [31:0] WB_DAT_I,        // Wishbone write data.
  input  wire logic [3:0]  WB_SEL_I,        // Wishbone byte select.
  input  wire logic        WB_WE_I,         // Wishbone write enable.
  input  wire logic        WB_CYC_I,        // Wishbone cycle.
  input  wire logic        WB_STB_I,        // Wishbone strobe.
  output logic [31:0]      WB_DAT_O,        // Wishbone read data.
  output logic             WB_ACK_O         // Wishbone acknowledge.
);

  // ----------------------------------------------------------------
  // Trigger synchroniser
  // ----------------------------------------------------------------
  logic trig_meta;
  logic trig_sync;
  logic next_trig_meta;
  logic next_trig_sync;

  always_comb
  begin
    next_trig_meta = TRIGGER_COIL_IN;
    next_trig_sync = trig_meta;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end
    else
    begin
      trig_meta <= next_trig_meta;
      trig_sync <= next_trig_sync;
    end
  end

  // ----------------------------------------------------------------
  // Send engine
  // ----------------------------------------------------------------
  logic                                 tx_valid;
  logic [put_pkg::VALUE_WIDTH-1:0]      tx_data;
  logic                                 active;
  logic                                 error;
  logic                                 sent_ev;
  logic                                 err_ev;

  // The value comes from same-clock logic, so it is read directly; it is
  // sampled in the cycle the synchronised edge is seen.
  put_sender #(
    .WIDTH (put_pkg::VALUE_WIDTH)
  ) sender (
    .clk_in       (CLOCK_IN),
    .rst_in       (SYS_RST_IN),
    .trigger_in   (trig_sync),
    .value_in     (PUT_VALUE_IN),
    .net_ok_in    (NET_OK_IN),
    .tx_ready_in  (TX_READY_IN),
    .tx_done_in   (TX_DONE_IN),
    .tx_fail_in   (TX_FAIL_IN),
    .tx_valid_out (tx_valid),
    .tx_data_out  (tx_data),
    .active_out   (active),
    .error_out    (error),
    .sent_ev_out  (sent_ev),
    .err_ev_out   (err_ev)
  );

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  logic                         display;
  logic                         next_display;
  logic [put_pkg::IRQ_WIDTH-1:0] irq_stat;
  logic [put_pkg::IRQ_WIDTH-1:0] next_irq_stat;
  logic [put_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [put_pkg::IRQ_WIDTH-1:0] next_irq_mask;
  logic [put_pkg::IRQ_WIDTH-1:0] events;
  logic [31:0]                  next_dat;
  logic                         next_ack;
  logic                         wr;
  logic [3:0]                   adr;
  logic                         in_map;

  assign events = {err_ev, sent_ev};
  assign adr    = WB_ADR_I[3:0];
  assign in_map = (WB_ADR_I[31:4] == 28'h000_0000);
  assign wr     = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0] & in_map;

  always_comb
  begin
    next_display  = display;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_ack      = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    next_dat      = 32'h0000_0000;
    if (wr && adr == put_pkg::CTRL_ADDR)
    begin
      next_display = WB_DAT_I[put_pkg::DISPLAY_BIT];
    end
    if (wr && adr == put_pkg::IRQ_MASK_ADDR)
    begin
      next_irq_mask = WB_DAT_I[put_pkg::IRQ_WIDTH-1:0];
    end
    if (wr && adr == put_pkg::IRQ_STAT_ADDR)
    begin
      next_irq_stat = irq_stat & ~WB_DAT_I[put_pkg::IRQ_WIDTH-1:0];
    end
    // A new event wins over a write-one-to-clear in the same cycle.
    next_irq_stat = next_irq_stat | events;
    unique case (adr)
      put_pkg::CTRL_ADDR:     next_dat = {31'h0000_0000, display};
      put_pkg::STATUS_ADDR:   next_dat = {28'h000_0000, error, active, trig_sync, NET_OK_IN};
      put_pkg::IRQ_STAT_ADDR: next_dat = {30'h0000_0000, irq_stat};
      put_pkg::IRQ_MASK_ADDR: next_dat = {30'h0000_0000, irq_mask};
      default:                next_dat = 32'h0000_0000;
    endcase
    // Upper address bits are decoded too, so the small map does not alias.
    if (!in_map)
    begin
      next_dat = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      display      <= put_pkg::DISPLAY_RESET;
      irq_stat     <= '0;
      irq_mask     <= '0;
      WB_ACK_O     <= 1'b0;
      WB_DAT_O     <= 32'h0000_0000;
      TX_VALID_OUT <= 1'b0;
      TX_DATA_OUT  <= 32'h0000_0000;
      CONFIRM_OUT  <= 1'b0;
      ACTIVE_OUT   <= 1'b0;
      ERROR_OUT    <= 1'b0;
      IRQ_OUT      <= 1'b0;
    end
    else
    begin
      display      <= next_display;
      irq_stat     <= next_irq_stat;
      irq_mask     <= next_irq_mask;
      WB_ACK_O     <= next_ack;
      WB_DAT_O     <= next_dat;
      TX_VALID_OUT <= tx_valid;
      TX_DATA_OUT  <= tx_data;
      CONFIRM_OUT  <= trig_sync;
      ACTIVE_OUT   <= active;
      ERROR_OUT    <= error;
      IRQ_OUT      <= |(irq_stat & irq_mask);
    end
  end

endmodule

// ### verification/put_block_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Contact and request timing checks
// ----------------------------------------------------------------
module put_block_props (
  input wire logic        CLOCK_IN,         // Clock.
  input wire logic        SYS_RST_IN,       // Reset.
  input wire logic        TRIGGER_COIL_IN,  // Coil pin.
  input wire logic        NET_OK_IN,        // Network health.
  input wire logic        TX_DONE_IN,       // Completion.
  input wire logic        TX_FAIL_IN,       // Failure flag.
  input wire logic        TX_VALID_OUT,     // Request.
  input wire logic [31:0] TX_DATA_OUT,      // Buffered value.
  input wire logic        CONFIRM_OUT,      // Confirm contact.
  input wire logic        ACTIVE_OUT,       // Active contact.
  input wire logic        ERROR_OUT,        // Error contact.
  input wire logic        IRQ_OUT           // Interrupt.
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  confirm_rise_a: assert property ($rose(CONFIRM_OUT) |-> $past(TRIGGER_COIL_IN, 3))
    else $error("confirm rose without coil");
  confirm_fall_a: assert property ($fell(CONFIRM_OUT) |-> !$past(TRIGGER_COIL_IN, 3))
    else $error("confirm fell with coil high");
  job_start_a: assert property ($rose(CONFIRM_OUT) && !ACTIVE_OUT && NET_OK_IN |-> ##[0:2] ACTIVE_OUT)
    else $error("pickup started no job");
  valid_start_a: assert property ($rose(ACTIVE_OUT) && NET_OK_IN |-> TX_VALID_OUT)
    else $error("request late after active");
  valid_active_a: assert property (TX_VALID_OUT |-> ACTIVE_OUT)
    else $error("request without active");
  data_hold_a: assert property (TX_VALID_OUT && $past(TX_VALID_OUT) |-> $stable(TX_DATA_OUT))
    else $error("data moved during request");
  net_down_a: assert property (!NET_OK_IN [*2] |-> !$rose(TX_VALID_OUT))
    else $error("request while network down");
  error_set_a: assert property (TX_DONE_IN && TX_FAIL_IN && ACTIVE_OUT |-> ##[1:3] ERROR_OUT)
    else $error("failed send left no error");
  error_clear_a: assert property ($fell(ERROR_OUT) |-> CONFIRM_OUT || $past(CONFIRM_OUT))
    else $error("error cleared without pickup");
  no_restart_a: assert property ($fell(ACTIVE_OUT) && CONFIRM_OUT && $past(CONFIRM_OUT) |=> !ACTIVE_OUT)
    else $error("job restarted on steady coil");
  job_c: cover property ($rose(TX_VALID_OUT));
  fail_c: cover property ($rose(ERROR_OUT));
  irq_c: cover property ($rose(IRQ_OUT));
endmodule
bind put_block put_block_props i_props (.*);

// ### verification/net_model.sv
`timescale 1ns/1ps
module net_model (
  input  wire logic clk_in,     // Clock.
  input  wire logic rst_in,     // Reset.
  input  wire logic valid_in,   // Request.
  input  wire logic bad_in,     // Report failure.
  input  wire logic slow_in,    // Slow completion.
  output logic      ready_out,  // Accept.
  output logic      done_out,   // Completion pulse.
  output logic      fail_out    // Failure flag.
);
  int cnt;
  initial {ready_out, done_out, fail_out} = 3'b000;
  // Every accepted request gets exactly one completion, good or bad.
  always @(posedge clk_in)
  begin
    ready_out <= 1'b0;
    done_out <= 1'b0;
    fail_out <= 1'b0;
    if (rst_in)
      cnt <= 0;
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      done_out <= 1'b1;
      fail_out <= bad_in;
      cnt <= 0;
    end
    // Valid is registered and falls a cycle after the accept is seen, so it
    // must not be taken a second time while the completion is going out.
    else if (valid_in && !ready_out && !done_out)
    begin
      ready_out <= 1'b1;
      cnt <= slow_in ? 9 : 1;
    end
  end
endmodule

// ### verification/tb_put_block.sv
`timescale 1ns/1ps
module tb_put_block;
  logic        CLOCK_IN = 1'b0, SYS_RST_IN = 1'b1, TRIGGER_COIL_IN = 1'b0, NET_OK_IN = 1'b1;
  logic        TX_READY_IN, TX_DONE_IN, TX_FAIL_IN, TX_VALID_OUT, CONFIRM_OUT;
  logic        ACTIVE_OUT, ERROR_OUT, IRQ_OUT, WB_ACK_O, bad = 1'b0, slow = 1'b0;
  logic        WB_WE_I = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
  logic [31:0] PUT_VALUE_IN = 32'h0, WB_ADR_I = 32'h0, WB_DAT_I = 32'h0;
  logic [31:0] TX_DATA_OUT, WB_DAT_O, rd, exp_q[$];
  logic [3:0]  WB_SEL_I = 4'hF;
  int          err_count = 0, n_checks = 0;
  put_block i_dut (.*);
  net_model i_net (.clk_in(CLOCK_IN), .rst_in(SYS_RST_IN), .valid_in(TX_VALID_OUT),
    .bad_in(bad), .slow_in(slow), .ready_out(TX_READY_IN), .done_out(TX_DONE_IN),
    .fail_out(TX_FAIL_IN));
  always #12.5 CLOCK_IN = ~CLOCK_IN;
  task automatic check(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    @(posedge CLOCK_IN);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
    n = 0;
    do @(posedge CLOCK_IN); while (WB_ACK_O !== 1'b1 && ++n < 50);
    check("ack", 1, WB_ACK_O);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
  endtask
  // The value is scrambled after capture so a late latch shows up as a data mismatch.
  task automatic job(input logic [31:0] v, input int hold);
    int n;
    @(posedge CLOCK_IN);
    TRIGGER_COIL_IN <= 1'b1;
    PUT_VALUE_IN <= v;
    if (NET_OK_IN)
      exp_q.push_back(v);
    repeat (5) @(posedge CLOCK_IN);
    PUT_VALUE_IN <= $urandom;
    check("active", NET_OK_IN, ACTIVE_OUT);
    check("confirm", 1, CONFIRM_OUT);
    repeat (hold) @(posedge CLOCK_IN);
    TRIGGER_COIL_IN <= 1'b0;
    n = 0;
    do @(posedge CLOCK_IN); while (ACTIVE_OUT !== 1'b0 && ++n < 40);
    check("active", 0, ACTIVE_OUT);
    repeat (4) @(posedge CLOCK_IN);
    check("confirm", 0, CONFIRM_OUT);
    $display("job %h done", v);
  endtask
  // Only sends that a job announced may appear; the oldest note is the one due.
  always @(posedge CLOCK_IN)
    if (TX_VALID_OUT === 1'b1 && TX_READY_IN === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("tx_extra", 0, 1);
      else
        check("tx_data", exp_q.pop_front(), TX_DATA_OUT);
    end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(10));
    repeat (2) @(posedge CLOCK_IN);
    SYS_RST_IN <= 1'b0;
    wb(0, {28'h0, put_pkg::CTRL_ADDR}, 0, rd);
    check("ctrl", {31'h0, put_pkg::DISPLAY_RESET}, rd);
    wb(0, {28'h0, put_pkg::STATUS_ADDR}, 0, rd);
    check("status", 32'h1, rd);
    wb(0, 32'h10, 0, rd);
    check("unmapped", 32'h0, rd);
    wb(1, {28'h0, put_pkg::IRQ_MASK_ADDR}, 32'h3, rd);
    slow <= 1'b1;
    job(32'h80000000, 1);
    slow <= 1'b0;
    job(32'h7FFFFFFF, 1);
    job($urandom, 1);
    check("irq", 1, IRQ_OUT);
    wb(0, {28'h0, put_pkg::IRQ_STAT_ADDR}, 0, rd);
    check("irq_stat", 32'h1, rd);
    wb(1, {28'h0, put_pkg::IRQ_STAT_ADDR}, 32'h1, rd);
    repeat (2) @(posedge CLOCK_IN);
    check("irq", 0, IRQ_OUT);
    bad <= 1'b1;
    job($urandom, 1);
    repeat (20) @(posedge CLOCK_IN);
    check("error", 1, ERROR_OUT);
    wb(0, {28'h0, put_pkg::IRQ_STAT_ADDR}, 0, rd);
    check("irq_stat", 32'h2, rd);
    bad <= 1'b0;
    wb(1, {28'h0, put_pkg::IRQ_MASK_ADDR}, 32'h0, rd);
    job($urandom, 1);
    check("error", 0, ERROR_OUT);
    check("irq", 0, IRQ_OUT);
    job($urandom, 60);
    NET_OK_IN <= 1'b0;
    job($urandom, 1);
    check("error", 1, ERROR_OUT);
    NET_OK_IN <= 1'b1;
    wb(1, {28'h0, put_pkg::CTRL_ADDR}, 32'h0, rd);
    wb(0, {28'h0, put_pkg::CTRL_ADDR}, 0, rd);
    check("ctrl", 32'h0, rd);
    check("tx_left", 0, 32'(exp_q.size()));
    results();
  end
  initial
  begin
    repeat (5000) @(posedge CLOCK_IN);
    err_count++;
    results();
  end
endmodule
